// >>> rtl/diu_core.v
// Summary of operation
// RULE_01: Halt instruction flushes the pipeline, then enters single-step emulation mode.
// RULE_02: Before single-step, abort any bus cycle and pending cache operation.
// RULE_03: Halt runs at every privilege level and never traps.
// RULE_04: Move-to-aux copies a general register, low bits only for narrow registers.
// RULE_05: Aux moves with index above 7 are undefined.
// RULE_06: Other diagnostic instructions trap when privilege level is not zero.
// RULE_07: Move-from-aux returns the register, zero filled above its width.
// RULE_08: Config bits 31..28: icache, dcache, burst write, little endian.
// RULE_09: Config bit 27 trap step, bit 24 sleep, bit 23 multiplier wait.
// RULE_10: Config bits 22..19 freeze successive 1K quarters of the icache.
// RULE_11: Reset clears defined config bits and the status word.
// RULE_12: Index 2 timer, 3/4 uncached base/mask, 5/6 write-through, 7 pc copy.
// RULE_13: Itag write: entry from bits 24:31, stores tag 0:19 and valid 20.
// RULE_14: Itag read: entry is way bit and bits 25:31, returns bits 0:21; the code returns bits 0:20 only.
// RULE_15: Icache word write uses entry 21:27, word 28:29, way config bit 26.
// RULE_16: Icache word read uses the same selection and returns the word.
// RULE_17: Dtag write: entry 25:31, stores tag 0:21, valid 22, dirty 23; the code writes dirty as 0.
// RULE_18: Dtag read: entry 25:31, returns bits 0:22.
// RULE_19: Dcache word write and read use entry 21:27, word 28:29, no way.
// RULE_20: Program counter copy is read-only; writes to it are ignored.
`timescale 1ns/1ns
`default_nettype none
`include "diu_defines.vh"
// Bit numbering: architectural bit n (0 = MSB) is Verilog bit 31-n.
module diu_core (
   input  wire        clock,
   input  wire        nrst,
   input  wire        insnValid,
   input  wire [31:0] insnWord,
   input  wire [1:0]  privLevel,
   input  wire [31:0] srcB,
   input  wire [31:0] srcR,
   input  wire [31:0] pcValue,
   input  wire [31:0] timerCount,
   input  wire        busCycleActive,
   input  wire        cacheOpPending,
   input  wire        stepRelease,
   output wire        resultValid,
   output reg  [31:0] resultData,
   output reg  [4:0]  resultReg,
   output reg         privTrap,
   output reg         pipeFlush,
   output reg         busAbort,
   output reg         cacheOpAbort,
   output reg         singleStep,
   output wire        timerLoad,
   output wire [31:0] timerLoadData,
   output wire [31:0] internalConfig,
   output wire [31:0] statusWord,
   output wire [31:0] uncachedBase,
   output wire [31:0] uncachedMask,
   output wire [31:0] wtBase,
   output wire [31:0] wtMask,
   output wire        icacheEnable,
   output wire        dcacheEnable,
   output wire        burstWriteEnable,
   output wire        littleEndian,
   output wire        trapStepEnable,
   output wire        sleepRequest,
   output wire        multWaitState,
   output wire [3:0]  icacheFreeze
);
   // ----------------------------------------
   // State encoding and storage
   // ----------------------------------------
   localparam ST_RUN   = 3'h1;
   localparam ST_DRAIN = 3'h2;
   localparam ST_STEP  = 3'h4;

   reg  [2:0]  state_q;
   reg  [31:0] cfg_q;
   reg  [31:0] psw_q;
   reg  [31:0] ucBase_q;
   reg  [31:0] ucMask_q;
   reg  [31:0] wtBase_q;
   reg  [31:0] wtMask_q;
   reg  [20:0] itag_q [0:255];
   reg  [23:0] dtag_q [0:127];
   reg  [31:0] iword_q [0:1023];
   reg  [31:0] dword_q [0:511];
   reg         rvalid_q;
   reg         tload_q;
   reg  [31:0] tdata_q;

   // ----------------------------------------
   // Sub-op decode
   // ----------------------------------------
   // Sub-ops outside this set, except halt, belong to other units and are left alone
   function knownSub;
      input [4:0] s;
      case (s)
         `DIU_SUB_MTAUX, `DIU_SUB_MFAUX,
         `DIU_SUB_WITAG, `DIU_SUB_RITAG,
         `DIU_SUB_WIWORD, `DIU_SUB_RIWORD,
         `DIU_SUB_WDTAG, `DIU_SUB_RDTAG,
         `DIU_SUB_WDWORD, `DIU_SUB_RDWORD: knownSub = 1'b1;
         default:                         knownSub = 1'b0;
      endcase
   endfunction

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   wire [4:0]  fieldB  = insnWord[25:21];
   wire [4:0]  subOp   = insnWord[4:0];
   wire        isDiag  = insnValid && insnWord[31:26] == `DIU_MAJOR_OP
                         && state_q == ST_RUN;
   wire        isHalt  = isDiag && subOp == `DIU_SUB_HALT;
   wire        priv0   = privLevel == 2'b00;
   wire        known   = knownSub(subOp);
   wire        doOp    = isDiag && known && priv0;
   // Halt is exempt: it must stop the core from any privilege level
   wire        trapNow = isDiag && !isHalt && known && !priv0; // see RULE_06

   // ----------------------------------------
   // Array indexes, big-endian bits 21:27 and 28:29 for words, 24:31 or 25:31 for tags
   // ----------------------------------------
   function [6:0] lineOf;
      input [31:0] v;
      lineOf = v[10:4];
   endfunction
   function [1:0] wordOf;
      input [31:0] v;
      wordOf = v[3:2];
   endfunction

   wire        way    = cfg_q[`DIU_CFG_WAY];
   wire [9:0]  iwIdx  = {way, lineOf(srcB), wordOf(srcB)}; // see RULE_15
   wire [8:0]  dwIdx  = {lineOf(srcB), wordOf(srcB)}; // see RULE_19
   wire [7:0]  itWIdx = srcB[7:0]; // see RULE_13
   wire [7:0]  itRIdx = {way, srcB[6:0]}; // see RULE_14
   wire [6:0]  dtIdx  = srcB[6:0]; // see RULE_17

   // ----------------------------------------
   // Aux register read mux
   // ----------------------------------------
   reg [31:0] auxRead;
   always @* begin
      case (fieldB[2:0]) // see RULE_12
         `DIU_AUX_CFG:    auxRead = cfg_q;
         `DIU_AUX_PSW:    auxRead = psw_q;
         `DIU_AUX_TMR:    auxRead = timerCount;
         `DIU_AUX_UCBASE: auxRead = ucBase_q;
         `DIU_AUX_UCMASK: auxRead = ucMask_q;
         `DIU_AUX_WTBASE: auxRead = wtBase_q;
         `DIU_AUX_WTMASK: auxRead = wtMask_q;
         default:         auxRead = pcValue;
      endcase
   end

   // ----------------------------------------
   // Aux registers
   // ----------------------------------------
   // Indexes above 7 are undefined; only the low three bits are decoded,
   // so higher indexes alias onto the eight defined slots.
   wire auxWr = doOp && subOp == `DIU_SUB_MTAUX; // see RULE_04
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cfg_q    <= `DIU_CFG_RESET; // see RULE_11
         psw_q    <= `DIU_PSW_RESET; // see RULE_11
         ucBase_q <= `DIU_AUX_RESET;
         ucMask_q <= `DIU_AUX_RESET;
         wtBase_q <= `DIU_AUX_RESET;
         wtMask_q <= `DIU_AUX_RESET;
         tload_q  <= 1'b0;
         tdata_q  <= `DIU_AUX_RESET;
      end else begin
         tload_q <= auxWr && fieldB[2:0] == `DIU_AUX_TMR;
         tdata_q <= srcR;
         if (auxWr) begin
            case (fieldB[2:0]) // see RULE_05
               `DIU_AUX_CFG:    cfg_q <= srcR & `DIU_CFG_MASK; // see RULE_04
               `DIU_AUX_PSW:    psw_q <= srcR;
               `DIU_AUX_UCBASE: ucBase_q <= srcR;
               `DIU_AUX_UCMASK: ucMask_q <= srcR;
               `DIU_AUX_WTBASE: wtBase_q <= srcR;
               `DIU_AUX_WTMASK: wtMask_q <= srcR;
               default: begin
                  // Timer is held outside; pc copy is not writable
                  cfg_q <= cfg_q; // see RULE_20
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Cache arrays
   // ----------------------------------------
   // Arrays have no reset: contents are undefined until written.
   always @(posedge clock) begin
      if (doOp) begin
         case (subOp)
            `DIU_SUB_WITAG:  itag_q[itWIdx] <= srcB[31:11]; // see RULE_13
            `DIU_SUB_WIWORD: iword_q[iwIdx] <= srcR; // see RULE_15
            `DIU_SUB_WDTAG:  dtag_q[dtIdx] <= {srcB[31:9], 1'b0}; // see RULE_17
            `DIU_SUB_WDWORD: dword_q[dwIdx] <= srcR; // see RULE_19
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Result path
   // ----------------------------------------
   // resultReg follows the t field every cycle; it only matters while
   // resultValid is high.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rvalid_q   <= 1'b0;
         resultData <= 32'h0000_0000;
         resultReg  <= 5'h00;
         privTrap   <= 1'b0;
      end else begin
         privTrap  <= trapNow; // see RULE_06
         rvalid_q  <= 1'b0;
         resultReg <= insnWord[9:5];
         if (doOp) begin
            rvalid_q <= 1'b1;
            case (subOp)
               `DIU_SUB_MFAUX:  resultData <= auxRead; // see RULE_07
               `DIU_SUB_RITAG:  resultData <= {itag_q[itRIdx], 11'h000}; // see RULE_14
               `DIU_SUB_RIWORD: resultData <= iword_q[iwIdx]; // see RULE_16
               `DIU_SUB_RDTAG:  resultData <= {dtag_q[dtIdx][23:1], 9'h000}; // see RULE_18
               `DIU_SUB_RDWORD: resultData <= dword_q[dwIdx]; // see RULE_19
               default:         rvalid_q <= 1'b0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Halt sequence
   // ----------------------------------------
   // Drain waits for the aborts to take before stepping, so no stale
   // bus cycle or cache fill completes under emulation control.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q      <= ST_RUN;
         pipeFlush    <= 1'b0;
         busAbort     <= 1'b0;
         cacheOpAbort <= 1'b0;
         singleStep   <= 1'b0;
      end else begin
         pipeFlush <= 1'b0;
         case (state_q)
            ST_RUN: begin
               if (isHalt) begin // see RULE_03
                  pipeFlush    <= 1'b1; // see RULE_01
                  busAbort     <= 1'b1; // see RULE_02
                  cacheOpAbort <= 1'b1; // see RULE_02
                  state_q      <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (!busCycleActive && !cacheOpPending) begin // see RULE_02
                  busAbort     <= 1'b0;
                  cacheOpAbort <= 1'b0;
                  singleStep   <= 1'b1; // see RULE_01
                  state_q      <= ST_STEP;
               end
            end
            ST_STEP: begin
               if (stepRelease) begin
                  singleStep <= 1'b0;
                  state_q    <= ST_RUN;
               end
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign resultValid      = rvalid_q;
   assign timerLoad        = tload_q;
   assign timerLoadData    = tdata_q;
   assign internalConfig   = cfg_q;
   assign statusWord       = psw_q;
   assign uncachedBase     = ucBase_q;
   assign uncachedMask     = ucMask_q;
   assign wtBase           = wtBase_q;
   assign wtMask           = wtMask_q;
   assign icacheEnable     = cfg_q[`DIU_CFG_ICEN]; // see RULE_08
   assign dcacheEnable     = cfg_q[`DIU_CFG_DCEN]; // see RULE_08
   assign burstWriteEnable = cfg_q[`DIU_CFG_BURST]; // see RULE_08
   assign littleEndian     = cfg_q[`DIU_CFG_LITTLE]; // see RULE_08
   assign trapStepEnable   = cfg_q[`DIU_CFG_TSTEP]; // see RULE_09
   assign sleepRequest     = cfg_q[`DIU_CFG_SLEEP]; // see RULE_09
   assign multWaitState    = cfg_q[`DIU_CFG_MULWAIT]; // see RULE_09
   // Quarter one under bit 22 maps to icacheFreeze[0]
   genvar q;
   generate
      for (q = 0; q < 4; q = q + 1) begin : gFreeze
         assign icacheFreeze[q] = cfg_q[`DIU_CFG_FRZ_HI - q]; // see RULE_10
      end
   endgenerate
endmodule // diu_core
`default_nettype wire

// >>> rtl/diu_defines.vh
`ifndef DIU_DEFINES_VH
`define DIU_DEFINES_VH
// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define DIU_MAJOR_OP        6'h05
`define DIU_SUB_MTAUX       5'h00
`define DIU_SUB_MFAUX       5'h01
`define DIU_SUB_WITAG       5'h08
`define DIU_SUB_RITAG       5'h09
`define DIU_SUB_WIWORD      5'h0A
`define DIU_SUB_RIWORD      5'h0B
`define DIU_SUB_WDTAG       5'h0C
`define DIU_SUB_RDTAG       5'h0D
`define DIU_SUB_WDWORD      5'h0E
`define DIU_SUB_RDWORD      5'h0F
`define DIU_SUB_HALT        5'h10
// ----------------------------------------
// Auxiliary register indexes
// ----------------------------------------
`define DIU_AUX_CFG         3'h0
`define DIU_AUX_PSW         3'h1
`define DIU_AUX_TMR         3'h2
`define DIU_AUX_UCBASE      3'h3
`define DIU_AUX_UCMASK      3'h4
`define DIU_AUX_WTBASE      3'h5
`define DIU_AUX_WTMASK      3'h6
`define DIU_AUX_PCCOPY      3'h7
// ----------------------------------------
// Configuration bit positions (bit 31 = MSB)
// ----------------------------------------
`define DIU_CFG_ICEN        31
`define DIU_CFG_DCEN        30
`define DIU_CFG_BURST       29
`define DIU_CFG_LITTLE      28
`define DIU_CFG_TSTEP       27
`define DIU_CFG_WAY         26
`define DIU_CFG_SLEEP       24
`define DIU_CFG_MULWAIT     23
`define DIU_CFG_FRZ_HI      22
`define DIU_CFG_FRZ_LO      19
`define DIU_CFG_MASK        32'hFDF8_0000
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DIU_CFG_RESET       32'h0000_0000
`define DIU_PSW_RESET       32'h0000_0000
`define DIU_AUX_RESET       32'h0000_0000
`endif

// >>> tb/diu_core_chk.sv
`timescale 1ns/1ns
`default_nettype none
module diu_core_chk (
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic        insnValid,
   input wire logic [31:0] insnWord,
   input wire logic [1:0]  privLevel,
   input wire logic [31:0] srcR,
   input wire logic [31:0] pcValue,
   input wire logic        busCycleActive,
   input wire logic        cacheOpPending,
   input wire logic        resultValid,
   input wire logic [31:0] resultData,
   input wire logic        privTrap,
   input wire logic        pipeFlush,
   input wire logic        busAbort,
   input wire logic        cacheOpAbort,
   input wire logic        singleStep,
   input wire logic        timerLoad,
   input wire logic [31:0] timerLoadData,
   input wire logic [31:0] internalConfig,
   input wire logic [31:0] statusWord
);
   // ----------------------------------------
   // Decode of what the core accepts
   // ----------------------------------------
   logic       take;
   logic [4:0] op;
   logic [2:0] idx;
   // Nothing is taken while draining or stepping
   assign take = insnValid && insnWord[31:26] == 6'h05 && !busAbort
                 && !singleStep;
   assign op  = insnWord[4:0];
   assign idx = insnWord[23:21];
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence haltSeq;
      take && op == 5'h10;
   endsequence
   sequence drainSeq;
      busAbort && !busCycleActive && !cacheOpPending;
   endsequence
   a_halt_flush:
   assert property (haltSeq |=> pipeFlush && busAbort && cacheOpAbort)
      else $error("halt did not flush and abort");
   a_halt_notrap:
   assert property (haltSeq |=> !privTrap) else $error("halt trapped");
   a_priv_trap:
   assert property (take && privLevel != 2'h0
      && op inside {5'h00, 5'h01, [5'h08:5'h0F]}
      |=> privTrap && !resultValid && !timerLoad)
      else $error("unprivileged diagnostic op not trapped");
   a_step_entry:
   assert property (drainSeq |=> singleStep && !busAbort)
      else $error("single step not entered after drain");
   a_pc_read:
   assert property (take && op == 5'h01 && idx == 3'h7 && privLevel == 2'h0
      |=> resultValid && resultData == $past(pcValue))
      else $error("pc copy read wrong");
   a_timer_load:
   assert property (take && op == 5'h00 && idx == 3'h2 && privLevel == 2'h0
      |=> timerLoad && timerLoadData == $past(srcR))
      else $error("timer load wrong");
   a_pc_ro:
   assert property (take && op == 5'h00 && idx == 3'h7
      |=> $stable(internalConfig) && $stable(statusWord) && !timerLoad)
      else $error("pc copy write changed state");
   a_cfg_reserved:
   assert property ((internalConfig & 32'h0207_FFFF) == 32'h0)
      else $error("reserved config bits set");
   a_reset_clear:
   assert property ($rose(nrst) |-> internalConfig == 0 && statusWord == 0)
      else $error("config or status not cleared by reset");
endmodule // diu_core_chk
bind diu_core diu_core_chk chk_u (.clock, .nrst, .insnValid, .insnWord,
   .privLevel, .srcR, .pcValue, .busCycleActive, .cacheOpPending,
   .resultValid, .resultData, .privTrap, .pipeFlush, .busAbort,
   .cacheOpAbort, .singleStep, .timerLoad, .timerLoadData,
   .internalConfig, .statusWord);
`default_nettype wire

// >>> tb/diu_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module diu_core_tb;
   logic        clock, nrst, insnValid, busCycleActive, cacheOpPending;
   logic        stepRelease, resultValid, privTrap, pipeFlush, busAbort;
   logic        cacheOpAbort, singleStep, timerLoad, icacheEnable;
   logic        dcacheEnable, burstWriteEnable, littleEndian;
   logic        trapStepEnable, sleepRequest, multWaitState;
   logic [1:0]  privLevel;
   logic [3:0]  icacheFreeze;
   logic [4:0]  resultReg;
   logic [31:0] insnWord, srcB, srcR, pcValue, timerCount, resultData;
   logic [31:0] timerLoadData, internalConfig, statusWord, uncachedBase;
   logic [31:0] uncachedMask, wtBase, wtMask, d, v;
   logic [31:0] aux [0:7];
   int          failCount = 0, checksDone = 0, cyc = 0;

   diu_core dut_u (.clock, .nrst, .insnValid, .insnWord, .privLevel, .srcB,
      .srcR, .pcValue, .timerCount, .busCycleActive, .cacheOpPending,
      .stepRelease, .resultValid, .resultData, .resultReg, .privTrap,
      .pipeFlush, .busAbort, .cacheOpAbort, .singleStep, .timerLoad,
      .timerLoadData, .internalConfig, .statusWord, .uncachedBase,
      .uncachedMask, .wtBase, .wtMask, .icacheEnable, .dcacheEnable,
      .burstWriteEnable, .littleEndian, .trapStepEnable, .sleepRequest,
      .multWaitState, .icacheFreeze);

   always #20 clock = ~clock;
   // Whole run needs about 340 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         failCount++;
         testDone();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task testDone();
      $display("checks %0d errors %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checksDone++;
      if (g !== e) begin
         $display("[ERR] %0t got %h exp %h", $time, g, e);
         failCount++;
      end
   endtask
   // Leaves insnValid high: caller issues again or idles at this edge
   task issue(input logic [4:0] s, input logic [4:0] b, input logic [4:0] t,
              input logic [1:0] p, input logic [31:0] sb, input logic [31:0] sr);
      insnWord = {6'h05, b, 5'h00, 6'h00, t, s};
      privLevel = p;
      srcB = sb;
      srcR = sr;
      insnValid = 1'b1;
      @(negedge clock);
   endtask
   task idle();
      insnValid = 1'b0;
      @(negedge clock);
   endtask
   function automatic logic [31:0] expAux(input logic [2:0] x);
      if (x == 3'h2) return timerCount;
      if (x == 3'h7) return pcValue;
      return aux[x];
   endfunction
   task wrAux(input logic [2:0] x, input logic [31:0] y);
      issue(5'h00, {2'h0, x}, 5'h00, 2'h0, 32'h0, y);
      if (x == 3'h0) aux[0] = y & 32'hFDF8_0000;
      else if (x != 3'h7) aux[x] = y;
      chk(timerLoad, x == 3'h2);
      if (x == 3'h2) chk(timerLoadData, y);
   endtask
   task rdAux(input logic [2:0] x, input logic [4:0] t);
      issue(5'h01, {2'h0, x}, t, 2'h0, 32'h0, 32'h0);
      chk({resultValid, resultReg}, {1'b1, t});
      chk(resultData, expAux(x));
   endtask
   task chkRegs();
      chk(internalConfig, aux[0]);
      chk(statusWord, aux[1]);
      chk(uncachedBase, aux[3]);
      chk(uncachedMask, aux[4]);
      chk(wtBase, aux[5]);
      chk(wtMask, aux[6]);
      chk({icacheEnable, dcacheEnable, burstWriteEnable, littleEndian,
           trapStepEnable, sleepRequest, multWaitState, icacheFreeze},
          {aux[0][31:27], aux[0][24:23], aux[0][19], aux[0][20],
           aux[0][21], aux[0][22]});
   endtask
   initial begin
      clock = 0; nrst = 0; insnValid = 0; insnWord = 0; privLevel = 0;
      srcB = 0; srcR = 0; pcValue = 0; timerCount = 0; stepRelease = 0;
      busCycleActive = 0; cacheOpPending = 0;
      foreach (aux[i]) aux[i] = 32'h0000_0000;
      void'($urandom(32'h0000_db6e));
      repeat (5) @(posedge clock);
      @(negedge clock);
      nrst = 1'b1;
      rdAux(3'h0, 5'h03);
      rdAux(3'h1, 5'h1F);
      for (int n = 0; n < 60; n++) begin
         d = (n == 8) ? 32'hFFFF_FFFF : $urandom;
         pcValue = $urandom;
         timerCount = $urandom;
         wrAux(n < 8 ? 3'(n) : 3'($urandom), d);
         rdAux(n < 8 ? 3'(n) : 3'($urandom), 5'($urandom));
         chkRegs();
      end
      for (int n = 0; n < 16; n++) begin
         v = $urandom;
         d = $urandom;
         wrAux(3'h0, {d[31:27], v[7], d[25:0]});
         issue(5'h08, 5'h02, 5'h00, 2'h0, v, 32'h0);
         issue(5'h09, 5'h02, 5'h04, 2'h0, v, 32'h0);
         chk(resultData & 32'hFFFF_F800, v & 32'hFFFF_F800);
         issue(5'h0A, 5'h02, 5'h00, 2'h0, v, d);
         wrAux(3'h0, aux[0] ^ 32'h0400_0000);
         issue(5'h0A, 5'h02, 5'h00, 2'h0, v, ~d);
         wrAux(3'h0, aux[0] ^ 32'h0400_0000);
         issue(5'h0B, 5'h02, 5'h05, 2'h0, v, 32'h0);
         chk(resultData, d);
         issue(5'h0C, 5'h02, 5'h00, 2'h0, v, 32'h0);
         issue(5'h0D, 5'h02, 5'h06, 2'h0, v, 32'h0);
         chk(resultData & 32'hFFFF_FE00, v & 32'hFFFF_FE00);
         issue(5'h0E, 5'h02, 5'h00, 2'h0, v, ~d);
         issue(5'h0F, 5'h02, 5'h07, 2'h0, v, 32'h0);
         chk(resultData, ~d);
      end
      for (int s = 0; s < 16; s++) begin
         if (s > 1 && s < 8) continue;
         issue(5'(s), 5'h01, 5'h03, 2'($urandom_range(3, 1)), $urandom,
               $urandom);
         chk({privTrap, resultValid, timerLoad}, 3'h4);
      end
      idle();
      chkRegs();
      busCycleActive = 1'b1;
      cacheOpPending = 1'b1;
      issue(5'h10, 5'h00, 5'h00, 2'h3, 32'h0, 32'h0);
      chk({pipeFlush, busAbort, cacheOpAbort}, 3'h7);
      chk(privTrap, 1'b0);
      issue(5'h01, 5'h01, 5'h01, 2'h0, 32'h0, 32'h0);
      chk({resultValid, pipeFlush}, 2'h0);
      idle();
      busCycleActive = 1'b0;
      @(negedge clock);
      chk(singleStep, 1'b0);
      cacheOpPending = 1'b0;
      for (int k = 0; k < 4 && singleStep !== 1'b1; k++) @(negedge clock);
      chk({singleStep, busAbort}, 2'h2);
      stepRelease = 1'b1;
      @(negedge clock);
      stepRelease = 1'b0;
      chk(singleStep, 1'b0);
      nrst = 1'b0;
      @(negedge clock);
      nrst = 1'b1;
      chk(internalConfig | statusWord, 32'h0);
      foreach (aux[i]) aux[i] = 32'h0000_0000;
      rdAux(3'h1, 5'h02);
      idle();
      chkRegs();
      testDone();
   end
endmodule // diu_core_tb
`default_nettype wire
